// ---- common/dbg_pkg.sv ----
// Constants shared by the debug breakpoint and watchpoint unit
package dbg_pkg;

    // ****************************************
    // Register indices and bank bases
    // ****************************************
    localparam logic [7:0] OFS_CAUSE_TYPE = 8'h15;
    localparam logic [7:0] OFS_TRIGGER_DATA = 8'h16;
    localparam logic [7:0] OFS_RUN_STOP = 8'h18;
    localparam logic [7:0] OFS_SCRATCH = 8'h20;
    localparam logic [7:0] OFS_IB_ADDR = 8'h30;
    localparam logic [7:0] OFS_IB_CTRL = 8'h40;
    localparam logic [7:0] OFS_DW_ADDR1 = 8'h50;
    localparam logic [7:0] OFS_DW_ADDR2 = 8'h60;
    localparam logic [7:0] OFS_DW_CTRL = 8'h70;
    localparam logic [7:0] OFS_RW_MASK = 8'h80;
    localparam logic [7:0] OFS_RW_VALUE = 8'h90;
    localparam logic [7:0] OFS_RW_CTRL = 8'h9C;

    // Bank of four: base in bits 7:2, member in bits 1:0
    localparam int BANK_LSB = 2;
    // Scratch bank of eight: base in bits 7:3
    localparam int SCRATCH_LSB = 3;

    // ****************************************
    // Control field layout
    // ****************************************
    localparam int CTRL_ENABLE_BIT = 0;
    localparam int CTRL_COND_BIT = 1;
    localparam int CTRL_LOAD_BIT = 2;
    localparam int CTRL_MASK_LSB = 16;
    localparam logic [31:0] IB_CTRL_WMASK = 32'h00FF_0003;
    localparam logic [31:0] DW_CTRL_WMASK = 32'h00FF_0007;
    localparam logic [31:0] RW_CTRL_WMASK = 32'h00FF_0003;
    localparam logic [31:0] RUN_STOP_WMASK = 32'h0000_00FF;
    localparam logic [31:0] WORD_RESET = 32'h0000_0000;

    // ****************************************
    // Debug cause type layout
    // ****************************************
    typedef enum logic [1:0] {
        CAUSE_NONE = 2'h0,
        CAUSE_IBREAK = 2'h1,
        CAUSE_DWATCH = 2'h3,
        CAUSE_RWATCH = 2'h2
    } cause_kind_t;
    localparam int CAUSE_INDEX_LSB = 2;

endpackage

// ---- core/debug_breakpoint_watchpoint_unit.sv ----
// Breakpoint, watchpoint, run-stop and scratch logic of one processor tile
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none

module debug_breakpoint_watchpoint_unit
    import dbg_pkg::*;
#(
    parameter int NUM_THREADS = 8,
    parameter int NUM_COMPARATORS = 4,
    parameter int NUM_SCRATCH = 8
)
(
    // Clock and reset
    input wire logic CLK,
    input wire logic RST,
    // Debug register port
    input wire logic [7:0] ADDR,
    input wire logic [31:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [31:0] RDATA,
    // Tile configuration view of the scratch words
    input wire logic [2:0] CFG_ADDR,
    input wire logic [31:0] CFG_WDATA,
    input wire logic CFG_WR,
    input wire logic CFG_RD,
    output logic [31:0] CFG_RDATA,
    // Program counter stream
    input wire logic PC_VALID,
    input wire logic [2:0] PC_THREAD,
    input wire logic [31:0] PC_VALUE,
    // Memory operation stream
    input wire logic MEM_VALID,
    input wire logic MEM_LOAD,
    input wire logic [2:0] MEM_THREAD,
    input wire logic [31:0] MEM_ADDR,
    // Resource access stream
    input wire logic RES_VALID,
    input wire logic [2:0] RES_THREAD,
    input wire logic [31:0] RES_ID,
    // Debug mode state and outcomes
    input wire logic DEBUG_MODE,
    output logic DEBUG_IRQ,
    output logic [7:0] THREAD_STOP
);

    // ****************************************
    // Elaboration checks
    // ****************************************
    // Masks and the stop vector are fixed 8-bit fields, banks fixed at four
    if (NUM_THREADS != 8 || NUM_COMPARATORS != 4 || NUM_SCRATCH != 8)
    begin : g_bad_params
        $error("Unsupported thread, comparator or scratch count");
    end

    // ****************************************
    // Register storage
    // ****************************************
    logic [31:0] ib_addr_reg [NUM_COMPARATORS];
    logic [31:0] ib_ctrl_reg [NUM_COMPARATORS];
    logic [31:0] dw_addr1_reg [NUM_COMPARATORS];
    logic [31:0] dw_addr2_reg [NUM_COMPARATORS];
    logic [31:0] dw_ctrl_reg [NUM_COMPARATORS];
    logic [31:0] rw_mask_reg [NUM_COMPARATORS];
    logic [31:0] rw_value_reg [NUM_COMPARATORS];
    logic [31:0] rw_ctrl_reg [NUM_COMPARATORS];
    logic [31:0] scratch_reg [NUM_SCRATCH];
    logic [31:0] trigger_data_reg;
    logic [31:0] cause_type_reg;
    logic [31:0] run_stop_reg;
    logic [31:0] rdata_reg;
    logic [31:0] cfg_rdata_reg;
    logic irq_reg;
    logic [7:0] stop_reg;

    // ****************************************
    // Address decode
    // ****************************************
    logic [1:0] member;
    logic [5:0] bank;
    logic [4:0] scratch_bank;
    logic [2:0] scratch_idx;
    logic sel_ib_addr;
    logic sel_ib_ctrl;
    logic sel_dw_addr1;
    logic sel_dw_addr2;
    logic sel_dw_ctrl;
    logic sel_rw_mask;
    logic sel_rw_value;
    logic sel_rw_ctrl;
    logic sel_scratch;
    logic sel_data;
    logic sel_cause;
    logic sel_stop;

    // Bank and member split of the register index
    assign member = ADDR[BANK_LSB-1:0];
    assign bank = ADDR[7:BANK_LSB];
    assign scratch_bank = ADDR[7:SCRATCH_LSB];
    assign scratch_idx = ADDR[SCRATCH_LSB-1:0];
    assign sel_ib_addr = (bank == OFS_IB_ADDR[7:BANK_LSB]);
    assign sel_ib_ctrl = (bank == OFS_IB_CTRL[7:BANK_LSB]);
    assign sel_dw_addr1 = (bank == OFS_DW_ADDR1[7:BANK_LSB]);
    assign sel_dw_addr2 = (bank == OFS_DW_ADDR2[7:BANK_LSB]);
    assign sel_dw_ctrl = (bank == OFS_DW_CTRL[7:BANK_LSB]);
    assign sel_rw_mask = (bank == OFS_RW_MASK[7:BANK_LSB]);
    assign sel_rw_value = (bank == OFS_RW_VALUE[7:BANK_LSB]);
    assign sel_rw_ctrl = (bank == OFS_RW_CTRL[7:BANK_LSB]);
    assign sel_scratch = (scratch_bank == OFS_SCRATCH[7:SCRATCH_LSB]);
    assign sel_data = (ADDR == OFS_TRIGGER_DATA);
    assign sel_cause = (ADDR == OFS_CAUSE_TYPE);
    assign sel_stop = (ADDR == OFS_RUN_STOP);

    // ****************************************
    // Read selection
    // ****************************************
    logic [31:0] read_mux;

    // Unmapped indices read as zero
    assign read_mux =
        sel_ib_addr ? ib_addr_reg[member] :
        sel_ib_ctrl ? ib_ctrl_reg[member] :
        sel_dw_addr1 ? dw_addr1_reg[member] :
        sel_dw_addr2 ? dw_addr2_reg[member] :
        sel_dw_ctrl ? dw_ctrl_reg[member] :
        sel_rw_mask ? rw_mask_reg[member] :
        sel_rw_value ? rw_value_reg[member] :
        sel_rw_ctrl ? rw_ctrl_reg[member] :
        sel_scratch ? scratch_reg[scratch_idx] :
        sel_data ? trigger_data_reg :
        sel_cause ? cause_type_reg :
        sel_stop ? run_stop_reg :
        WORD_RESET;

    // Read data stands in the cycle after the strobe only
    always_ff @(posedge CLK)
    begin
        if (RST)
            rdata_reg <= WORD_RESET;
        else
            rdata_reg <= RD ? read_mux : WORD_RESET;
    end

    // Configuration view reads the same scratch words
    always_ff @(posedge CLK)
    begin
        if (RST)
            cfg_rdata_reg <= WORD_RESET;
        else
            cfg_rdata_reg <= CFG_RD ? scratch_reg[CFG_ADDR] : WORD_RESET;
    end

    // ****************************************
    // Comparators and their registers
    // ****************************************
    logic [NUM_COMPARATORS-1:0] ib_hit;
    logic [NUM_COMPARATORS-1:0] dw_hit;
    logic [NUM_COMPARATORS-1:0] rw_hit;

    genvar gi;
    generate
        for (gi = 0; gi < NUM_COMPARATORS; gi++)
        begin : g_cmp
            logic wr_here;
            logic ib_thread_ok;
            logic ib_equal;
            logic dw_thread_ok;
            logic dw_a;
            logic dw_b;
            logic dw_cond;
            logic dw_kind_ok;
            logic rw_thread_ok;
            logic rw_a;

            assign wr_here = WR && (member == 2'(gi));

            // Instruction breakpoint: thread mask, equal or unequal PC
            assign ib_thread_ok = ib_ctrl_reg[gi][CTRL_MASK_LSB + PC_THREAD];
            assign ib_equal = (PC_VALUE == ib_addr_reg[gi]);
            assign ib_hit[gi] = PC_VALID && ib_ctrl_reg[gi][CTRL_ENABLE_BIT]
                && ib_thread_ok
                && (ib_ctrl_reg[gi][CTRL_COND_BIT] ? !ib_equal : ib_equal);

            // Data watch: A and B are matches on the two addresses
            assign dw_thread_ok = dw_ctrl_reg[gi][CTRL_MASK_LSB + MEM_THREAD];
            assign dw_a = (MEM_ADDR == dw_addr1_reg[gi]);
            assign dw_b = (MEM_ADDR == dw_addr2_reg[gi]);
            assign dw_cond = dw_ctrl_reg[gi][CTRL_COND_BIT] ? (dw_a || dw_b)
                : (dw_a && dw_b);
            // Stores always qualify, loads only when allowed
            assign dw_kind_ok = !MEM_LOAD || dw_ctrl_reg[gi][CTRL_LOAD_BIT];
            assign dw_hit[gi] = MEM_VALID && dw_ctrl_reg[gi][CTRL_ENABLE_BIT]
                && dw_thread_ok && dw_kind_ok && dw_cond;

            // Resource watch: masked compare, B is the complement of A
            assign rw_thread_ok = rw_ctrl_reg[gi][CTRL_MASK_LSB + RES_THREAD];
            assign rw_a = ((RES_ID & rw_mask_reg[gi])
                == (rw_value_reg[gi] & rw_mask_reg[gi]));
            assign rw_hit[gi] = RES_VALID && rw_ctrl_reg[gi][CTRL_ENABLE_BIT]
                && rw_thread_ok
                && (rw_ctrl_reg[gi][CTRL_COND_BIT] ? !rw_a : rw_a);

            // Breakpoint address and control; reserved bits never stored
            always_ff @(posedge CLK)
            begin
                if (RST)
                begin
                    ib_addr_reg[gi] <= WORD_RESET;
                    ib_ctrl_reg[gi] <= WORD_RESET;
                end
                else if (wr_here && sel_ib_addr)
                    ib_addr_reg[gi] <= WDATA;
                else if (wr_here && sel_ib_ctrl)
                    ib_ctrl_reg[gi] <= WDATA & IB_CTRL_WMASK;
            end

            // Data watch addresses and control
            always_ff @(posedge CLK)
            begin
                if (RST)
                begin
                    dw_addr1_reg[gi] <= WORD_RESET;
                    dw_addr2_reg[gi] <= WORD_RESET;
                    dw_ctrl_reg[gi] <= WORD_RESET;
                end
                else if (wr_here && sel_dw_addr1)
                    dw_addr1_reg[gi] <= WDATA;
                else if (wr_here && sel_dw_addr2)
                    dw_addr2_reg[gi] <= WDATA;
                else if (wr_here && sel_dw_ctrl)
                    dw_ctrl_reg[gi] <= WDATA & DW_CTRL_WMASK;
            end

            // Resource watch mask, value and control
            always_ff @(posedge CLK)
            begin
                if (RST)
                begin
                    rw_mask_reg[gi] <= WORD_RESET;
                    rw_value_reg[gi] <= WORD_RESET;
                    rw_ctrl_reg[gi] <= WORD_RESET;
                end
                else if (wr_here && sel_rw_mask)
                    rw_mask_reg[gi] <= WDATA;
                else if (wr_here && sel_rw_value)
                    rw_value_reg[gi] <= WDATA;
                else if (wr_here && sel_rw_ctrl)
                    rw_ctrl_reg[gi] <= WDATA & RW_CTRL_WMASK;
            end
        end
    endgenerate

    // ****************************************
    // Scratch words
    // ****************************************
    genvar gs;
    generate
        for (gs = 0; gs < NUM_SCRATCH; gs++)
        begin : g_scratch
            logic dbg_wr;
            logic cfg_wr;

            assign dbg_wr = WR && sel_scratch && (scratch_idx == 3'(gs));
            assign cfg_wr = CFG_WR && (CFG_ADDR == 3'(gs));

            // Debug port wins a same-cycle collision with the config view
            always_ff @(posedge CLK)
            begin
                if (RST)
                    scratch_reg[gs] <= WORD_RESET;
                else if (dbg_wr)
                    scratch_reg[gs] <= WDATA;
                else if (cfg_wr)
                    scratch_reg[gs] <= CFG_WDATA;
            end
        end
    endgenerate

    // ****************************************
    // Trigger priority and capture
    // ****************************************
    logic any_ib;
    logic any_dw;
    logic any_rw;
    logic fire;
    logic [1:0] ib_idx;
    logic [1:0] dw_idx;
    logic [1:0] rw_idx;
    logic [1:0] win_idx;
    cause_kind_t win_kind;
    logic [31:0] cause_next;
    logic [31:0] data_next;

    // Lowest numbered comparator wins within a kind
    function automatic logic [1:0] first_set(input logic [3:0] v);
        first_set = v[0] ? 2'h0 : v[1] ? 2'h1 : v[2] ? 2'h2 : 2'h3;
    endfunction

    // Comparators are silent while the tile already sits in debug mode
    assign any_ib = |ib_hit && !DEBUG_MODE;
    assign any_dw = |dw_hit && !DEBUG_MODE;
    assign any_rw = |rw_hit && !DEBUG_MODE;
    assign fire = any_ib || any_dw || any_rw;
    assign ib_idx = first_set(ib_hit);
    assign dw_idx = first_set(dw_hit);
    assign rw_idx = first_set(rw_hit);
    // Breakpoints take precedence over data, data over resources
    assign win_kind = any_ib ? CAUSE_IBREAK : any_dw ? CAUSE_DWATCH : CAUSE_RWATCH;
    assign win_idx = any_ib ? ib_idx : any_dw ? dw_idx : rw_idx;
    assign cause_next = {28'h000_0000, win_idx, win_kind};
    // Data only changes on a watchpoint; a breakpoint leaves it alone
    assign data_next = any_ib ? trigger_data_reg
        : any_dw ? MEM_ADDR
        : RES_ID;

    // Captured data; a trigger wins over a software write in the same cycle
    always_ff @(posedge CLK)
    begin
        if (RST)
            trigger_data_reg <= WORD_RESET;
        else if (fire)
            trigger_data_reg <= data_next;
        else if (WR && sel_data)
            trigger_data_reg <= WDATA;
    end

    // Cause type is read-only and rewritten on every trigger
    always_ff @(posedge CLK)
    begin
        if (RST)
            cause_type_reg <= WORD_RESET;
        else if (fire)
            cause_type_reg <= cause_next;
    end

    // Interrupt request pulse, one cycle per trigger
    always_ff @(posedge CLK)
    begin
        if (RST)
            irq_reg <= 1'b0;
        else
            irq_reg <= fire;
    end

    // ****************************************
    // Run-stop control
    // ****************************************
    // Reserved bits above the thread vector are not stored
    always_ff @(posedge CLK)
    begin
        if (RST)
            run_stop_reg <= WORD_RESET;
        else if (WR && sel_stop)
            run_stop_reg <= WDATA & RUN_STOP_WMASK;
    end

    // Stops apply only once debug mode is left, enabling single steps
    always_ff @(posedge CLK)
    begin
        if (RST)
            stop_reg <= WORD_RESET[7:0];
        else
            stop_reg <= DEBUG_MODE ? WORD_RESET[7:0] : run_stop_reg[7:0];
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign RDATA = rdata_reg;
    assign CFG_RDATA = cfg_rdata_reg;
    assign DEBUG_IRQ = irq_reg;
    assign THREAD_STOP = stop_reg;

endmodule

`default_nettype wire

// ---- verif/core_stream_model.sv ----
// Core pipeline model that presents PC, memory and resource events
`timescale 1ns/1ps
`default_nettype none

module core_stream_model
(
    // Clock
    input wire logic CLK,
    // Event streams toward the debug unit
    output logic PC_VALID,
    output logic [2:0] PC_THREAD,
    output logic [31:0] PC_VALUE,
    output logic MEM_VALID,
    output logic MEM_LOAD,
    output logic [2:0] MEM_THREAD,
    output logic [31:0] MEM_ADDR,
    output logic RES_VALID,
    output logic [2:0] RES_THREAD,
    output logic [31:0] RES_ID
);
    // Streams stay quiet until an event is asked for
    initial
    begin
        {PC_VALID, MEM_VALID, RES_VALID, MEM_LOAD} = 4'h0;
        {PC_THREAD, MEM_THREAD, RES_THREAD} = 9'h000;
        {PC_VALUE, MEM_ADDR, RES_ID} = 96'h0;
    end

    // One event for one cycle; idle lines show the inverse so stale data never matches
    task automatic issue(input int kind, input logic [2:0] thr, input logic [31:0] v, input bit ld);
        @(posedge CLK);
        {PC_VALID, MEM_VALID, RES_VALID} <= {kind == 0, kind == 1, kind == 2};
        {PC_THREAD, MEM_THREAD, RES_THREAD} <= {thr, thr, thr};
        {PC_VALUE, MEM_ADDR, RES_ID, MEM_LOAD} <= {v, v, v, ld};
        @(posedge CLK);
        {PC_VALID, MEM_VALID, RES_VALID} <= 3'h0;
        {PC_VALUE, MEM_ADDR, RES_ID} <= {~v, ~v, ~v};
    endtask
endmodule

`default_nettype wire

// ---- verif/dbg_unit_sva.sv ----
// Port-level assertions for the debug breakpoint and watchpoint unit
`timescale 1ns/1ps
`default_nettype none

module dbg_unit_sva
    import dbg_pkg::*;
(
    // Clock and reset
    input wire logic CLK,
    input wire logic RST,
    // Register ports
    input wire logic [7:0] ADDR,
    input wire logic [31:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    input wire logic [31:0] RDATA,
    input wire logic [2:0] CFG_ADDR,
    input wire logic CFG_WR,
    input wire logic CFG_RD,
    input wire logic [31:0] CFG_RDATA,
    // Core streams and outcomes
    input wire logic PC_VALID,
    input wire logic MEM_VALID,
    input wire logic [31:0] MEM_ADDR,
    input wire logic RES_VALID,
    input wire logic [31:0] RES_ID,
    input wire logic DEBUG_MODE,
    input wire logic DEBUG_IRQ,
    input wire logic [7:0] THREAD_STOP
);
    default clocking @(posedge CLK); endclocking
    default disable iff (RST);

    // No event and no write, so captured state cannot move
    wire logic quiet;
    assign quiet = !PC_VALID && !MEM_VALID && !RES_VALID && !WR;

    // ****************************************
    // Checks
    // ****************************************
    rdata_idle_a: assert property (!$past(RD) |-> RDATA == 32'h0)
        else $error("read data not zero outside reply");
    cfg_idle_a: assert property (!$past(CFG_RD) |-> CFG_RDATA == 32'h0)
        else $error("config read data not zero outside reply");
    stop_debug_a: assert property ($past(DEBUG_MODE) |-> THREAD_STOP == 8'h00)
        else $error("threads held while in debug mode");
    irq_debug_a: assert property ($past(DEBUG_MODE) |-> !DEBUG_IRQ)
        else $error("debug interrupt while in debug mode");
    irq_cause_a: assert property (DEBUG_IRQ |-> $past(PC_VALID || MEM_VALID || RES_VALID))
        else $error("debug interrupt without core event");
    run_stop_a: assert property ((WR && ADDR == OFS_RUN_STOP) ##1 (!WR && !DEBUG_MODE)
        |=> THREAD_STOP == $past(WDATA[7:0], 2)) else $error("run-stop vector not applied");
    scratch_share_a: assert property ((WR && ADDR[7:3] == OFS_SCRATCH[7:3])
        ##1 (!WR && !CFG_WR) ##1 (CFG_RD && !CFG_WR && CFG_ADDR == $past(ADDR[2:0], 2))
        |=> CFG_RDATA == $past(WDATA, 3)) else $error("scratch word differs between ports");
    data_addr_a: assert property ((MEM_VALID && !PC_VALID && !RES_VALID) ##1
        (DEBUG_IRQ && quiet) ##1 (quiet && RD && ADDR == OFS_TRIGGER_DATA)
        |=> RDATA == $past(MEM_ADDR, 3)) else $error("effective address not captured");
    res_id_a: assert property ((RES_VALID && !PC_VALID && !MEM_VALID) ##1
        (DEBUG_IRQ && quiet) ##1 (quiet && RD && ADDR == OFS_TRIGGER_DATA)
        |=> RDATA == $past(RES_ID, 3)) else $error("resource identifier not captured");
    break_cause_a: assert property ((PC_VALID && !MEM_VALID && !RES_VALID) ##1
        (DEBUG_IRQ && quiet) ##1 quiet ##1 (RD && ADDR == OFS_CAUSE_TYPE)
        |=> RDATA[1:0] == CAUSE_IBREAK) else $error("breakpoint cause not recorded");

    // Main scenarios reached
    cover property (DEBUG_IRQ && $past(MEM_VALID));
    cover property (DEBUG_IRQ && $past(RES_VALID));
    cover property (THREAD_STOP != 8'h00);
endmodule

`default_nettype wire

// ---- verif/debug_breakpoint_watchpoint_unit_bench.sv ----
// Self-checking bench for the debug breakpoint and watchpoint unit
`timescale 1ns/1ps
`default_nettype none

module debug_breakpoint_watchpoint_unit_bench
    import dbg_pkg::*;
;
    logic CLK = 1'h0;
    logic RST = 1'h1;
    logic [7:0] ADDR = 8'h00;
    logic [31:0] WDATA = 32'h0;
    logic WR = 1'h0;
    logic RD = 1'h0;
    logic [2:0] CFG_ADDR = 3'h0;
    logic [31:0] CFG_WDATA = 32'h0;
    logic CFG_WR = 1'h0;
    logic CFG_RD = 1'h0;
    logic DEBUG_MODE = 1'h0;
    logic [31:0] RDATA, CFG_RDATA, PC_VALUE, MEM_ADDR, RES_ID;
    logic PC_VALID, MEM_VALID, MEM_LOAD, RES_VALID, DEBUG_IRQ;
    logic [2:0] PC_THREAD, MEM_THREAD, RES_THREAD;
    logic [7:0] THREAD_STOP;
    // Reference register file and comparator bank bases
    logic [31:0] mreg [256] = '{default: 32'h0};
    logic [7:0] regs [8] = '{8'h30, 8'h40, 8'h50, 8'h60, 8'h70, 8'h80, 8'h90, 8'h9C};
    logic [7:0] fa [3] = '{OFS_IB_ADDR, OFS_DW_ADDR1, OFS_RW_MASK};
    logic [7:0] sa [3] = '{OFS_IB_ADDR, OFS_DW_ADDR2, OFS_RW_VALUE};
    logic [7:0] cb [3] = '{OFS_IB_CTRL, OFS_DW_CTRL, OFS_RW_CTRL};
    int code [3] = '{CAUSE_IBREAK, CAUSE_DWATCH, CAUSE_RWATCH};
    int n_mismatch = 0;
    int cmp_count = 0;
    int r, kd, t, e;
    logic [31:0] d, v;
    bit ld, dm;

    debug_breakpoint_watchpoint_unit debug_breakpoint_watchpoint_unit_i (.*);
    core_stream_model core_stream_model_i (.*);

    // 100 MHz clock
    initial forever #5 CLK = ~CLK;

    // ****************************************
    // Reference model
    // ****************************************
    // Writable bits of each index; unmapped and read-only places keep nothing
    function automatic logic [31:0] wmask(logic [7:0] a);
        if (a == OFS_TRIGGER_DATA || a[7:3] == OFS_SCRATCH[7:3]) return 32'hFFFF_FFFF;
        if (a == OFS_RUN_STOP) return RUN_STOP_WMASK;
        if (a[7:2] == OFS_IB_CTRL[7:2]) return IB_CTRL_WMASK;
        if (a[7:2] == OFS_DW_CTRL[7:2]) return DW_CTRL_WMASK;
        if (a[7:2] == OFS_RW_CTRL[7:2]) return RW_CTRL_WMASK;
        // Address banks hold four words each; the rest of their range is unmapped
        if (a[7:2] inside {OFS_IB_ADDR[7:2], OFS_DW_ADDR1[7:2], OFS_DW_ADDR2[7:2],
            OFS_RW_MASK[7:2], OFS_RW_VALUE[7:2]}) return 32'hFFFF_FFFF;
        return 32'h0;
    endfunction

    // Whether comparator k of kind kd fires on value v from thread t
    function automatic bit hit(int kd, int k, int t, logic [31:0] v, bit ld);
        logic [31:0] c, p, q;
        bit a;
        c = mreg[cb[kd] + k];
        p = mreg[fa[kd] + k];
        q = mreg[sa[kd] + k];
        a = (kd == 2) ? ((v & p) == (q & p)) : (v == p);
        if (kd == 1)
            a = c[1] ? (a || v == q) : (a && v == q);
        else
            a = a ^ c[1];
        return c[0] && c[16 + t] && a && (kd != 1 || !ld || c[2]);
    endfunction

    // ****************************************
    // Bus tasks and checks
    // ****************************************
    task automatic chk(logic [31:0] seen, logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(bit cf, logic [7:0] a, logic [31:0] d);
        logic [7:0] x;
        x = cf ? {OFS_SCRATCH[7:3], a[2:0]} : a;
        @(posedge CLK);
        {WR, CFG_WR, ADDR, CFG_ADDR, WDATA, CFG_WDATA} <= {!cf, cf, a, a[2:0], d, d};
        mreg[x] = (mreg[x] & ~wmask(x)) | (d & wmask(x));
        @(posedge CLK);
        {WR, CFG_WR} <= 2'h0;
    endtask

    task automatic rd(bit cf, logic [7:0] a);
        @(posedge CLK);
        {RD, CFG_RD, ADDR, CFG_ADDR} <= {!cf, cf, a, a[2:0]};
        @(posedge CLK);
        {RD, CFG_RD} <= 2'h0;
        #1 chk(cf ? CFG_RDATA : RDATA, mreg[cf ? {OFS_SCRATCH[7:3], a[2:0]} : a]);
    endtask

    task automatic stop_test();
        $display("mismatches %0d, comparisons %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // A hang counts as a mismatch
    initial
    begin
        repeat (100000) @(posedge CLK);
        n_mismatch++;
        stop_test();
    end

    // ****************************************
    // Main sequence
    // ****************************************
    initial
    begin
        void'($urandom(35681));
        repeat (16) @(posedge CLK);
        RST <= 1'h0;
        for (int i = 0; i < 256; i++)
            rd(0, i[7:0]);
        for (int i = 0; i < 256; i++)
        begin
            wr(0, i[7:0], $urandom);
            rd(0, i[7:0]);
        end
        $display("register map test done");
        for (int i = 0; i < 16; i++)
        begin
            wr(i[3], {OFS_SCRATCH[7:3], i[2:0]}, $urandom);
            rd(!i[3], {OFS_SCRATCH[7:3], i[2:0]});
        end
        $display("shared scratch test done");
        // Held threads, released in debug mode, held again on return
        d = $urandom;
        wr(0, OFS_RUN_STOP, d);
        @(posedge CLK);
        #1 chk(THREAD_STOP, d[7:0]);
        @(posedge CLK) DEBUG_MODE <= 1'h1;
        @(posedge CLK);
        #1 chk(THREAD_STOP, 32'h0);
        @(posedge CLK) DEBUG_MODE <= 1'h0;
        @(posedge CLK);
        #1 chk(THREAD_STOP, d[7:0]);
        $display("run-stop test done");
        // Random comparator setup, one core event, then captured state read back
        for (int n = 0; n < 300; n++)
        begin
            r = $urandom % 8;
            d = (r % 3 == 1) ? $urandom : $urandom % 4;
            wr(0, regs[r] + 8'($urandom % 4), d);
            kd = $urandom % 3;
            t = $urandom % 8;
            v = $urandom % 4;
            ld = $urandom % 2;
            dm = ($urandom % 8) == 0;
            e = 0;
            for (int k = 3; k >= 0; k--)
                if (hit(kd, k, t, v, ld))
                    e = k + 1;
            if (e > 0 && !dm)
                mreg[OFS_CAUSE_TYPE] = 32'((e - 1) * 4 + code[kd]);
            if (e > 0 && !dm && kd > 0)
                mreg[OFS_TRIGGER_DATA] = v;
            @(posedge CLK) DEBUG_MODE <= dm;
            core_stream_model_i.issue(kd, t[2:0], v, ld);
            // The pulse stands only in the cycle right after the event edge
            #1 chk(DEBUG_IRQ, e > 0 && !dm);
            @(posedge CLK);
            {DEBUG_MODE, RD, ADDR} <= {1'h0, 1'h1, OFS_TRIGGER_DATA};
            @(posedge CLK) ADDR <= OFS_CAUSE_TYPE;
            #1 chk(RDATA, mreg[OFS_TRIGGER_DATA]);
            @(posedge CLK) RD <= 1'h0;
            #1 chk(RDATA, mreg[OFS_CAUSE_TYPE]);
        end
        $display("trigger test done");
        stop_test();
    end
endmodule

bind debug_breakpoint_watchpoint_unit dbg_unit_sva dbg_unit_sva_i (.*);

`default_nettype wire
